// *** verilog/port_pin_defines.svh ***
// Register offsets, field positions and reset values of the pin-control port.
// Assumes a byte-wide register port with a 4-bit register address.
`ifndef PORT_PIN_DEFINES_SVH
`define PORT_PIN_DEFINES_SVH

`define REG_PORT_DATA 4'h0
`define REG_DIRECTION 4'h1
`define REG_PULL_ENABLE 4'h2
`define REG_SLEW_ENABLE 4'h3
`define REG_DRIVE_SELECT 4'h4
`define REG_STATUS_CONTROL 4'h5
`define REG_PIN_SELECT 4'h6
`define REG_POLARITY 4'h7
`define REG_IRQ_STATUS 4'h8
`define REG_IRQ_MASK 4'h9

`define SC_FLAG_BIT 3
`define SC_ACK_BIT 2
`define SC_IE_BIT 1
`define SC_MODE_BIT 0
`define IRQ_REQ_BIT 0

`define RESET_BYTE 8'h00
`define RESET_BIT 1'b0

`endif

// *** verilog/port_pin_pkg.sv ***
// Types shared by the pin-control port.
// Assumes nothing beyond the defines header.
`default_nettype none

package port_pin_pkg;
    typedef logic [3:0] reg_addr_t;
    typedef logic [7:0] reg_byte_t;
    typedef enum logic {DETECT_EDGE, DETECT_EDGE_LEVEL} detect_mode_t;
endpackage

`default_nettype wire

// *** verilog/pin_sync.sv ***
// Multi-stage synchroniser for a bank of input pins.
// Assumes pins change freely with respect to ref_clk.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned STAGES = 2
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage [STAGES];

    if (STAGES < 2) begin : g_bad_stages
        $error("pin_sync needs at least two stages");
    end

    // Only the next stage, or the output for the last stage, ever looks at a stage
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            for (int i = 0; i < STAGES; i++) begin
                stage[i] <= '0;
            end
        end else begin
            stage[0] <= raw;
            for (int i = 1; i < STAGES; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign synced = stage[STAGES-1];
endmodule

`default_nettype wire

// *** verilog/pin_event_detect.sv ***
// Per-pin interrupt event detector: edges, optionally also levels.
// Assumes its pin levels are already synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none

module pin_event_detect #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] level,
    input wire logic [WIDTH-1:0] select,
    input wire logic [WIDTH-1:0] polarity,
    input wire logic level_mode,
    output logic [WIDTH-1:0] events
);
    logic [WIDTH-1:0] prev;
    logic primed;

    // Polarity 0: falling edge or low level; polarity 1: rising or high
    function automatic logic hit(input logic was, input logic now, input logic pol,
                                 input logic lvl);
        logic edge_seen;
        edge_seen = (now == pol) && (was != pol);
        return edge_seen || (lvl && (now == pol));
    endfunction

    // No edge on the first cycle out of reset: prev is not yet real
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            prev <= '0;
            primed <= 1'b0;
        end else begin
            prev <= level;
            primed <= 1'b1;
        end
    end

    always_comb begin
        events = '0;
        for (int i = 0; i < WIDTH; i++) begin
            events[i] = select[i] && primed && hit(prev[i], level[i], polarity[i], level_mode);
        end
    end
endmodule

`default_nettype wire

// *** verilog/port_pin_ctrl.sv ***
// Top of one parallel port: registers, pin drive controls, pin interrupt.
// Assumes a single-cycle register port and pins sampled on ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "port_pin_defines.svh"

module port_pin_ctrl
    import port_pin_pkg::*;
#(
    parameter int unsigned PIN_COUNT = 8,
    parameter int unsigned SYNC_STAGES = 2
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire reg_addr_t reg_addr,
    input wire reg_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output reg_byte_t reg_rdata,
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe_n,
    output logic [PIN_COUNT-1:0] slew_limit,
    output logic [PIN_COUNT-1:0] drive_high,
    output logic [PIN_COUNT-1:0] pull_up_en,
    output logic [PIN_COUNT-1:0] pull_down_en,
    output logic port_irq_request,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    localparam reg_byte_t RESET_BYTE = `RESET_BYTE;

    if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : g_bad_width
        $error("port_pin_ctrl serves one to eight pins");
    end

    logic [PIN_COUNT-1:0] port_data;
    logic [PIN_COUNT-1:0] direction_bits;
    logic [PIN_COUNT-1:0] pull_enable_bits;
    logic [PIN_COUNT-1:0] slew_enable_bits;
    logic [PIN_COUNT-1:0] drive_strength_bits;
    logic [PIN_COUNT-1:0] irq_pin_select_bits;
    logic [PIN_COUNT-1:0] irq_polarity_bits;
    logic irq_flag;
    logic irq_enable_bit;
    detect_mode_t detect_mode_bit;
    logic irq_status;
    logic irq_mask;

    logic [PIN_COUNT-1:0] pin_synced;
    logic [PIN_COUNT-1:0] pin_events;
    logic any_event;
    logic irq_acknowledge;
    logic next_request;
    logic status_read;
    reg_byte_t next_rdata;

    // Zero-extends a pin vector to a register byte
    function automatic reg_byte_t widen(input logic [PIN_COUNT-1:0] v);
        reg_byte_t b;
        b = '0;
        b[PIN_COUNT-1:0] = v;
        return b;
    endfunction

    function automatic logic is_write(input reg_addr_t a, input reg_addr_t target,
                                      input logic wr);
        return wr && (a == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin input path

    pin_sync #(
        .WIDTH(PIN_COUNT),
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .raw(pin_in),
        .synced(pin_synced)
    );

    pin_event_detect #(
        .WIDTH(PIN_COUNT)
    ) u_detect (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .level(pin_synced),
        .select(irq_pin_select_bits),
        .polarity(irq_polarity_bits),
        .level_mode(detect_mode_bit == DETECT_EDGE_LEVEL),
        .events(pin_events)
    );

    assign any_event = |pin_events;

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            port_data <= '0;
            direction_bits <= '0;
            pull_enable_bits <= '0;
        end else begin
            if (is_write(reg_addr, `REG_PORT_DATA, reg_wr)) begin
                port_data <= reg_wdata[PIN_COUNT-1:0];
            end
            if (is_write(reg_addr, `REG_DIRECTION, reg_wr)) begin
                direction_bits <= reg_wdata[PIN_COUNT-1:0];
            end
            if (is_write(reg_addr, `REG_PULL_ENABLE, reg_wr)) begin
                pull_enable_bits <= reg_wdata[PIN_COUNT-1:0];
            end
        end
    end

    // Slew reset value is not trusted by software either way
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            slew_enable_bits <= '0;
            drive_strength_bits <= '0;
        end else begin
            if (is_write(reg_addr, `REG_SLEW_ENABLE, reg_wr)) begin
                slew_enable_bits <= reg_wdata[PIN_COUNT-1:0];
            end
            if (is_write(reg_addr, `REG_DRIVE_SELECT, reg_wr)) begin
                drive_strength_bits <= reg_wdata[PIN_COUNT-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irq_pin_select_bits <= '0;
            irq_polarity_bits <= '0;
        end else begin
            if (is_write(reg_addr, `REG_PIN_SELECT, reg_wr)) begin
                irq_pin_select_bits <= reg_wdata[PIN_COUNT-1:0];
            end
            if (is_write(reg_addr, `REG_POLARITY, reg_wr)) begin
                irq_polarity_bits <= reg_wdata[PIN_COUNT-1:0];
            end
        end
    end

    // The flag bit position is not writable here
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irq_enable_bit <= `RESET_BIT;
            detect_mode_bit <= DETECT_EDGE;
        end else if (is_write(reg_addr, `REG_STATUS_CONTROL, reg_wr)) begin
            irq_enable_bit <= reg_wdata[`SC_IE_BIT];
            detect_mode_bit <= detect_mode_t'(reg_wdata[`SC_MODE_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port interrupt flag and request

    assign irq_acknowledge = is_write(reg_addr, `REG_STATUS_CONTROL, reg_wr)
                             && reg_wdata[`SC_ACK_BIT];

    // A new event beats a simultaneous acknowledge; in level mode this
    // keeps the flag up for as long as an active level persists
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irq_flag <= `RESET_BIT;
        end else if (any_event) begin
            irq_flag <= 1'b1;
        end else if (irq_acknowledge) begin
            irq_flag <= 1'b0;
        end
    end

    assign next_request = irq_flag && irq_enable_bit;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            port_irq_request <= 1'b0;
        end else begin
            port_irq_request <= next_request;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status, mask and line

    assign status_read = reg_rd && (reg_addr == `REG_IRQ_STATUS);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irq_status <= `RESET_BIT;
        end else if (next_request && !port_irq_request) begin
            irq_status <= 1'b1;
        end else if (status_read) begin
            irq_status <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irq_mask <= `RESET_BIT;
        end else if (is_write(reg_addr, `REG_IRQ_MASK, reg_wr)) begin
            irq_mask <= reg_wdata[`IRQ_REQ_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_status && irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive controls

    // Output-only settings are masked off on input pins so the pads
    // never see a stale slew or strength choice
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pin_out <= '0;
            pin_oe_n <= '1;
            slew_limit <= '0;
            drive_high <= '0;
        end else begin
            pin_out <= port_data & direction_bits;
            pin_oe_n <= ~direction_bits;
            slew_limit <= slew_enable_bits & direction_bits;
            drive_high <= drive_strength_bits & direction_bits;
        end
    end

    // Pulls act on inputs only; pull-down needs select and polarity both set
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pull_up_en <= '0;
            pull_down_en <= '0;
        end else begin
            pull_up_en <= pull_enable_bits & ~direction_bits
                          & ~(irq_pin_select_bits & irq_polarity_bits);
            pull_down_en <= pull_enable_bits & ~direction_bits
                            & irq_pin_select_bits & irq_polarity_bits;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read path

    always_comb begin
        next_rdata = RESET_BYTE;
        case (reg_addr)
            `REG_PORT_DATA: begin
                next_rdata = widen((port_data & direction_bits) | (pin_synced & ~direction_bits));
            end
            `REG_DIRECTION: next_rdata = widen(direction_bits);
            `REG_PULL_ENABLE: next_rdata = widen(pull_enable_bits);
            `REG_SLEW_ENABLE: next_rdata = widen(slew_enable_bits);
            `REG_DRIVE_SELECT: next_rdata = widen(drive_strength_bits);
            `REG_STATUS_CONTROL: begin
                // Acknowledge position always reads zero
                next_rdata[`SC_FLAG_BIT] = irq_flag;
                next_rdata[`SC_IE_BIT] = irq_enable_bit;
                next_rdata[`SC_MODE_BIT] = detect_mode_bit;
            end
            `REG_PIN_SELECT: next_rdata = widen(irq_pin_select_bits);
            `REG_POLARITY: next_rdata = widen(irq_polarity_bits);
            `REG_IRQ_STATUS: next_rdata[`IRQ_REQ_BIT] = irq_status;
            `REG_IRQ_MASK: next_rdata[`IRQ_REQ_BIT] = irq_mask;
            default: next_rdata = RESET_BYTE;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata <= RESET_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= RESET_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    chk_flag_on_event: assert property (any_event |=> irq_flag)
        else $error("flag not set after pin event");

    chk_write_no_set: assert property (
        (!irq_flag && !any_event && reg_wr && reg_addr == `REG_STATUS_CONTROL) |=> !irq_flag)
        else $error("write set the flag");

    chk_ack_clears: assert property (
        (irq_acknowledge && !any_event && irq_flag) |=> !irq_flag)
        else $error("acknowledge did not clear flag");

    chk_ack_reads_zero: assert property (
        (reg_rd && reg_addr == `REG_STATUS_CONTROL) |=> !reg_rdata[`SC_ACK_BIT])
        else $error("acknowledge bit read as one");

    chk_request_gating: assert property (
        ##1 port_irq_request == ($past(irq_flag) && $past(irq_enable_bit)))
        else $error("request not gated by enable");

    // The flag may rise from zero here, so only its value is checked
    chk_level_rearm: assert property (
        (irq_acknowledge && detect_mode_bit == DETECT_EDGE_LEVEL && any_event)
        |=> irq_flag)
        else $error("level mode flag dropped on acknowledge");

    chk_edge_only: assert property (
        (detect_mode_bit == DETECT_EDGE && pin_events != '0) |->
        ((pin_events & ~((pin_synced ~^ irq_polarity_bits)
        & ($past(pin_synced) ^ irq_polarity_bits))) == '0))
        else $error("edge mode event without matching edge");

    chk_select_excludes: assert property ((pin_events & ~irq_pin_select_bits) == '0)
        else $error("event on unselected pin");

    chk_output_masked: assert property (
        ##1 ((slew_limit | drive_high) & ~$past(direction_bits)) == '0)
        else $error("output setting on input pin");

    chk_oe_direction: assert property (##1 pin_oe_n == ~$past(direction_bits))
        else $error("output enable does not follow direction");

    chk_pull_down_irq: assert property (
        ##1 (pull_down_en & ~$past(irq_pin_select_bits & irq_polarity_bits)) == '0)
        else $error("pull-down outside interrupt setup");

    chk_sync_delay: assert property (
        (pin_in != '0) ##1 $stable(pin_in)
        |=> ##(SYNC_STAGES - 2) (pin_synced == $past(pin_in, 2)))
        else $error("synchroniser latency wrong");

    cov_edge_flag: cover property (detect_mode_bit == DETECT_EDGE && any_event ##1 irq_flag);
    cov_level_rearm: cover property (irq_acknowledge && detect_mode_bit == DETECT_EDGE_LEVEL
                                     && any_event);
    cov_irq_line: cover property (irq);
    cov_pull_down: cover property (pull_down_en != '0);
endmodule

`default_nettype wire

// *** verification/pin_partner.sv ***
// Far side of the port: external drivers, pulls and floating pins.
// Assumes the design's active-low output enables and pull controls.
`timescale 1ns/100ps
`default_nettype none

module pin_partner (
    input wire logic ref_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_down_en,
    input wire logic [7:0] ext_drive,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    logic [7:0] float_pat = 8'h55;

    // Floating pins wander so that a stale level is never trusted
    always @(posedge ref_clk) begin
        float_pat <= ~float_pat;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_drive[i]) begin
                pin_in[i] = ext_level[i];
            end else if (pull_up_en[i]) begin
                pin_in[i] = 1'b1;
            end else if (pull_down_en[i]) begin
                pin_in[i] = 1'b0;
            end else begin
                pin_in[i] = float_pat[i];
            end
        end
    end
endmodule

`default_nettype wire

// *** verification/port_pin_ctrl_tb.sv ***
// Self-checking bench for the pin-control port with a pin partner model.
// Assumes the register map of the defines header and a 50 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "port_pin_defines.svh"

module port_pin_ctrl_tb
    import port_pin_pkg::*;
;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    reg_addr_t reg_addr = 4'h0;
    reg_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    reg_byte_t reg_rdata;
    logic [7:0] pin_in, pin_out, pin_oe_n, slew_limit, drive_high, pull_up_en, pull_down_en;
    logic port_irq_request, irq;
    logic [7:0] ext_drive = 8'h00;
    logic [7:0] ext_level = 8'h00;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 57;
    int cyc = 0;

    always #10 ref_clk = ~ref_clk;

    port_pin_ctrl port_pin_ctrl_inst (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .slew_limit(slew_limit),
        .drive_high(drive_high), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .port_irq_request(port_irq_request), .irq(irq));

    pin_partner pin_partner_inst (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_drive(ext_drive),
        .ext_level(ext_level), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic reg_byte_t up_exp(reg_byte_t pe, dir, sel, pol);
        return pe & ~dir & ~(sel & pol);
    endfunction

    function automatic reg_byte_t dn_exp(reg_byte_t pe, dir, sel, pol);
        return pe & ~dir & sel & pol;
    endfunction

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input reg_addr_t a, input reg_byte_t d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input reg_addr_t a, input reg_byte_t e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Bounded wait; a miss shows up in the following compare
    task automatic wait_req();
        for (int i = 0; i < 12 && port_irq_request !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        reg_byte_t dir, pe, se, ds, sel, pol, dat;
        int p;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        wait_cyc(1);
        check(pin_oe_n, 8'hFF);
        check(slew_limit | drive_high | pull_up_en | pull_down_en, 8'h00);
        for (int a = 1; a < 16; a++) begin
            rd_chk(a[3:0], 8'h00);
        end
        wr(4'hA, 8'hFF);
        rd_chk(4'hA, 8'h00);
        wr(`REG_STATUS_CONTROL, 8'h08);
        rd_chk(`REG_STATUS_CONTROL, 8'h00);
        $display("test reset done");

        for (int n = 0; n < 16; n++) begin
            dir = 8'($random(seed));
            pe = 8'($random(seed));
            se = 8'($random(seed));
            ds = 8'($random(seed));
            sel = 8'($random(seed));
            pol = 8'($random(seed));
            dat = 8'($random(seed));
            wr(`REG_DIRECTION, dir);
            wr(`REG_PULL_ENABLE, pe);
            wr(`REG_SLEW_ENABLE, se);
            wr(`REG_DRIVE_SELECT, ds);
            wr(`REG_PIN_SELECT, sel);
            wr(`REG_POLARITY, pol);
            wr(`REG_PORT_DATA, dat);
            wait_cyc(2);
            check(slew_limit, se & dir);
            check(drive_high, ds & dir);
            check(pin_oe_n, ~dir);
            check(pin_out, dat & dir);
            check(pull_up_en, up_exp(pe, dir, sel, pol));
            check(pull_down_en, dn_exp(pe, dir, sel, pol));
            rd_chk(`REG_SLEW_ENABLE, se);
            rd_chk(`REG_DRIVE_SELECT, ds);
        end
        $display("test config done");

        ext_drive <= 8'hFF;
        ext_level <= 8'hA5;
        wr(`REG_DIRECTION, 8'h00);
        wr(`REG_PULL_ENABLE, 8'h00);
        wait_cyc(4);
        rd_chk(`REG_PORT_DATA, 8'hA5);
        for (int k = 0; k < 4; k++) begin
            p = {$random(seed)} % 8;
            pol = k[0] ? 8'hFF : 8'h00;
            ext_level <= ~pol;
            wr(`REG_PIN_SELECT, 8'h01 << p);
            wr(`REG_POLARITY, pol);
            wait_cyc(6);
            wr(`REG_STATUS_CONTROL, 8'h06);
            wait_cyc(2);
            rd_chk(`REG_STATUS_CONTROL, 8'h02);
            ext_level[(p + 1) % 8] <= pol[0];
            wait_cyc(6);
            check({7'h00, port_irq_request}, 8'h00);
            ext_level[p] <= pol[0];
            wait_req();
            check({7'h00, port_irq_request}, 8'h01);
            rd_chk(`REG_STATUS_CONTROL, 8'h0A);
            wr(`REG_STATUS_CONTROL, 8'h06);
            wait_cyc(2);
            rd_chk(`REG_STATUS_CONTROL, 8'h02);
            ext_level <= ~pol;
            wait_cyc(6);
            check({7'h00, port_irq_request}, 8'h00);
        end
        $display("test edge done");

        wr(`REG_STATUS_CONTROL, 8'h04);
        ext_level[p] <= pol[0];
        wait_cyc(6);
        check({7'h00, port_irq_request}, 8'h00);
        rd_chk(`REG_STATUS_CONTROL, 8'h08);
        rd_chk(`REG_IRQ_STATUS, 8'h01);
        rd_chk(`REG_IRQ_STATUS, 8'h00);
        wr(`REG_STATUS_CONTROL, 8'h02);
        wait_req();
        check({7'h00, port_irq_request}, 8'h01);
        rd_chk(`REG_IRQ_STATUS, 8'h01);
        check({7'h00, irq}, 8'h00);
        wr(`REG_IRQ_MASK, 8'h01);
        wr(`REG_STATUS_CONTROL, 8'h06);
        ext_level[p] <= ~pol[0];
        wait_cyc(6);
        ext_level[p] <= pol[0];
        wait_req();
        wait_cyc(3);
        check({7'h00, irq}, 8'h01);
        rd_chk(`REG_IRQ_STATUS, 8'h01);
        wait_cyc(2);
        check({7'h00, irq}, 8'h00);
        $display("test enable and mask done");

        wr(`REG_STATUS_CONTROL, 8'h07);
        wait_cyc(6);
        rd_chk(`REG_STATUS_CONTROL, 8'h0B);
        wr(`REG_STATUS_CONTROL, 8'h07);
        wait_cyc(1);
        rd_chk(`REG_STATUS_CONTROL, 8'h0B);
        ext_level[p] <= ~pol[0];
        wait_cyc(6);
        wr(`REG_STATUS_CONTROL, 8'h07);
        wait_cyc(2);
        rd_chk(`REG_STATUS_CONTROL, 8'h03);
        $display("test level done");

        wr(`REG_PIN_SELECT, 8'h81);
        wr(`REG_POLARITY, 8'h00);
        ext_level <= 8'hFF;
        foreach (dat[q]) begin
            if (q == 0 || q == 7) begin
                wait_cyc(6);
                wr(`REG_STATUS_CONTROL, 8'h06);
                wait_cyc(2);
                ext_level[q] <= 1'b0;
                wait_req();
                check({7'h00, port_irq_request}, 8'h01);
                ext_level[q] <= 1'b1;
            end
        end
        $display("test or done");
        close_out();
    end
endmodule

`default_nettype wire
